// file: common/pfc_consts.vh
// Offsets, field positions, codes and reset values for pin function control
// Assumes an 8-bit register port with 16-bit addresses.
`ifndef PFC_CONSTS_VH
`define PFC_CONSTS_VH
`define PFC_ADDR_LOCAL 16'h003f
`define PFC_ADDR_PRI 16'h0040
`define PFC_ADDR_SEC 16'h0041
`define PFC_ADDR_XFER 16'h000f
`define PFC_LOCAL_DIS_BIT 7
`define PFC_GLOB_HI 7
`define PFC_GLOB_LO 6
`define PFC_B0_HI 5
`define PFC_B0_LO 3
`define PFC_A0_HI 2
`define PFC_A0_LO 0
`define PFC_SECB_HI 7
`define PFC_SECB_LO 4
`define PFC_SECA_HI 3
`define PFC_SECA_LO 0
`define PFC_RST_LOCAL 8'h00
`define PFC_RST_PRI 8'h3f
`define PFC_RST_SEC 8'h00
`define PFC_GLOB_FULLOFF 2'h0
`define PFC_GLOB_STANDBY 2'h1
`define PFC_GLOB_OFF 2'h2
`define PFC_PRI_ALERT 3'h0
`define PFC_PRI_LMFC 3'h1
`define PFC_PRI_SEC 3'h6
`define PFC_PRI_DIS 3'h7
`define PFC_SEC_NCO 4'h0
`define PFC_SEC_XFER 4'h1
`define PFC_SEC_LEAD 4'h8
`define PFC_SEC_FOLLOW 4'h9
`define PFC_XFER_CYCLES 4'h2
`endif

// file: logic/pfc_pin_function_control.v
// Pin function control: power-down pin gating and A0/B0 pin roles
// Assumes a single-cycle register port on core_clk; pins are asynchronous.
// Functional notes
// - Local disable bit ignores power-down pin
// - Field 00: pin means full power-down
// - Field 01: pin means standby
// - Field 10: pin ignored
// - Enabled pin overrides register power mode
// - B0 selector: LMFC, secondary, disabled
// - A0 selector: fast-detect, LMFC, secondary, disabled
// - Disabled pin is pulled-down input; reset disabled
// - B0 secondary used only under code 110
// - Secondary 0000 NCO select, 0001 transfer
// - 1000 lead trigger out, 1001 follower in
// - Transfer copies pending values; register bit self-clears
// - A0 secondary offers same choices
`include "pfc_consts.vh"
module pfc_pin_function_control
(
   input wire core_clk,
   input wire reset,
   input wire regWrite,
   input wire regRead,
   input wire [15:0] regAddr,
   input wire [7:0] regWdata,
   output reg [7:0] regRdata_r,
   input wire powerdown_standby_pin,
   input wire [1:0] regPowerMode,
   output reg [1:0] powerMode_r,
   output reg chipPowerDown_r,
   output reg chipStandby_r,
   input wire overrange_alert_output,
   input wire lmfcPulse,
   input wire lead_next_trigger_out,
   input wire multipurpose_pin_a_zero_in,
   output wire multipurpose_pin_a_zero_out,
   output wire multipurpose_pin_a_zero_oe,
   output wire pinAPullDown,
   input wire multipurpose_pin_b_zero_in,
   output wire multipurpose_pin_b_zero_out,
   output wire multipurpose_pin_b_zero_oe,
   output wire pinBPullDown,
   output reg ncoChannelSel_r,
   output reg follower_next_trigger_in_r,
   output reg transferStrobe_r,
   input wire transferDone
);
   localparam [1:0] PM_FULLOFF = 2'h3;
   localparam [1:0] PM_STANDBY = 2'h2;

   reg [7:0] localGate_r;
   reg [7:0] pinCtlPri_r;
   reg [7:0] pinCtlSec_r;
   reg xferBit_r;
   reg [1:0] pdSync_r;
   reg [1:0] aSync_r;
   reg [1:0] bSync_r;
   reg xferInPrev_r;
   wire pinActive;
   wire pdEnabled;
   wire [1:0] globalFn;
   wire aNco;
   wire aXfer;
   wire aFollow;
   wire bNco;
   wire bXfer;
   wire bFollow;
   wire xferIn;
   wire xferRequest;

   // Address match shared by every write and the transfer request
   function addrHit;
      input [15:0] addr;
      input [15:0] target;
      begin
         addrHit = (addr == target);
      end
   endfunction

   assign globalFn = pinCtlPri_r[`PFC_GLOB_HI:`PFC_GLOB_LO];
   assign pdEnabled = ~localGate_r[`PFC_LOCAL_DIS_BIT] &
      ((globalFn == `PFC_GLOB_FULLOFF) |
      (globalFn == `PFC_GLOB_STANDBY));
   assign pinActive = pdEnabled & pdSync_r[1];

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         pdSync_r <= 2'h0;
         aSync_r <= 2'h0;
         bSync_r <= 2'h0;
      end
      else
      begin
         pdSync_r <= {pdSync_r[0], powerdown_standby_pin};
         aSync_r <= {aSync_r[0], multipurpose_pin_a_zero_in};
         bSync_r <= {bSync_r[0], multipurpose_pin_b_zero_in};
      end
   end

   // Pin wins over register power mode
   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         powerMode_r <= 2'h0;
         chipPowerDown_r <= 1'b0;
         chipStandby_r <= 1'b0;
      end
      else if (pinActive)
      begin
         chipPowerDown_r <= (globalFn == `PFC_GLOB_FULLOFF);
         chipStandby_r <= (globalFn == `PFC_GLOB_STANDBY);
         powerMode_r <= (globalFn == `PFC_GLOB_FULLOFF) ? PM_FULLOFF :
            PM_STANDBY;
      end
      else
      begin
         chipPowerDown_r <= 1'b0;
         chipStandby_r <= 1'b0;
         powerMode_r <= regPowerMode;
      end
   end

   pfc_pin_role roleA
   (
      .primarySel(pinCtlPri_r[`PFC_A0_HI:`PFC_A0_LO]),
      .secondarySel(pinCtlSec_r[`PFC_SECA_HI:`PFC_SECA_LO]),
      .alertAllowed(1'b1),
      .overrangeAlert(overrange_alert_output),
      .lmfcPulse(lmfcPulse),
      .leadTrigger(lead_next_trigger_out),
      .pinOut(multipurpose_pin_a_zero_out),
      .pinOe(multipurpose_pin_a_zero_oe),
      .pinPullDown(pinAPullDown),
      .ncoSelRole(aNco),
      .xferRole(aXfer),
      .followRole(aFollow)
   );

   // B0 has no fast-detect role, so code 000 leaves it pulled down
   pfc_pin_role roleB
   (
      .primarySel(pinCtlPri_r[`PFC_B0_HI:`PFC_B0_LO]),
      .secondarySel(pinCtlSec_r[`PFC_SECB_HI:`PFC_SECB_LO]),
      .alertAllowed(1'b0),
      .overrangeAlert(overrange_alert_output),
      .lmfcPulse(lmfcPulse),
      .leadTrigger(lead_next_trigger_out),
      .pinOut(multipurpose_pin_b_zero_out),
      .pinOe(multipurpose_pin_b_zero_oe),
      .pinPullDown(pinBPullDown),
      .ncoSelRole(bNco),
      .xferRole(bXfer),
      .followRole(bFollow)
   );

   assign xferIn = (aXfer & aSync_r[1]) | (bXfer & bSync_r[1]);
   // Rising edge of pin trigger or register bit starts a transfer
   assign xferRequest = (xferIn & ~xferInPrev_r) |
      (regWrite & addrHit(regAddr, `PFC_ADDR_XFER) & regWdata[0]);

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         xferInPrev_r <= 1'b0;
         ncoChannelSel_r <= 1'b0;
         follower_next_trigger_in_r <= 1'b0;
         transferStrobe_r <= 1'b0;
      end
      else
      begin
         xferInPrev_r <= xferIn;
         ncoChannelSel_r <= (aNco & aSync_r[1]) | (bNco & bSync_r[1]);
         // Follower input supplied by the neighbouring lead device
         follower_next_trigger_in_r <= (aFollow & aSync_r[1]) |
            (bFollow & bSync_r[1]);
         // One cycle only; copy logic must act on it at once
         transferStrobe_r <= xferRequest;
      end
   end

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         localGate_r <= `PFC_RST_LOCAL;
         pinCtlPri_r <= `PFC_RST_PRI;
         pinCtlSec_r <= `PFC_RST_SEC;
         xferBit_r <= 1'b0;
      end
      else
      begin
         if (regWrite & addrHit(regAddr, `PFC_ADDR_LOCAL))
            localGate_r <= {regWdata[7], 7'h00};
         if (regWrite & addrHit(regAddr, `PFC_ADDR_PRI))
            pinCtlPri_r <= regWdata;
         if (regWrite & addrHit(regAddr, `PFC_ADDR_SEC))
            pinCtlSec_r <= regWdata;
         // Set wins over the completion clear
         if (regWrite & addrHit(regAddr, `PFC_ADDR_XFER) & regWdata[0])
            xferBit_r <= 1'b1;
         else if (transferDone)
            xferBit_r <= 1'b0;
      end
   end

   always @(posedge core_clk or posedge reset)
   begin
      if (reset)
         regRdata_r <= 8'h00;
      else if (regRead)
      begin
         case (regAddr)
            `PFC_ADDR_LOCAL: regRdata_r <= localGate_r;
            `PFC_ADDR_PRI: regRdata_r <= pinCtlPri_r;
            `PFC_ADDR_SEC: regRdata_r <= pinCtlSec_r;
            `PFC_ADDR_XFER: regRdata_r <= {7'h00, xferBit_r};
            default: regRdata_r <= 8'h00;
         endcase
      end
   end
endmodule

// file: logic/pfc_pin_role.v
// Per-pin role decoder: primary and secondary selector to pin behaviour
// Assumes selector values are stable register outputs.
`include "pfc_consts.vh"
module pfc_pin_role
(
   input wire [2:0] primarySel,
   input wire [3:0] secondarySel,
   input wire alertAllowed,
   input wire overrangeAlert,
   input wire lmfcPulse,
   input wire leadTrigger,
   output reg pinOut,
   output reg pinOe,
   output reg pinPullDown,
   output reg ncoSelRole,
   output reg xferRole,
   output reg followRole
);
   always @*
   begin
      pinOut = 1'b0;
      pinOe = 1'b0;
      pinPullDown = 1'b0;
      ncoSelRole = 1'b0;
      xferRole = 1'b0;
      followRole = 1'b0;
      case (primarySel)
         `PFC_PRI_ALERT:
         begin
            // Only the A0 pin carries the overrange alert
            pinOe = alertAllowed;
            pinOut = alertAllowed & overrangeAlert;
            pinPullDown = ~alertAllowed;
         end
         `PFC_PRI_LMFC:
         begin
            pinOe = 1'b1;
            pinOut = lmfcPulse;
         end
         `PFC_PRI_SEC:
         begin
            // Secondary only consulted under code 110
            case (secondarySel)
               `PFC_SEC_NCO: ncoSelRole = 1'b1;
               `PFC_SEC_XFER: xferRole = 1'b1;
               `PFC_SEC_LEAD:
               begin
                  pinOe = 1'b1;
                  pinOut = leadTrigger;
               end
               `PFC_SEC_FOLLOW: followRole = 1'b1;
               default: pinPullDown = 1'b1;
            endcase
         end
         default: pinPullDown = 1'b1;
      endcase
   end
endmodule

// file: verification/pfc_board_model.sv
// Board side of the two multipurpose pins
// Resolves pin levels from design and board enables.
module pfc_board_model
(
   input wire aOut,
   input wire aOe,
   input wire bOut,
   input wire bOe,
   input wire bPull,
   input wire drvEn,
   input wire drvVal,
   output wire aIn,
   output wire bIn
);
   timeunit 1ns;
   timeprecision 1ns;
   assign aIn = aOe ? aOut : 1'b0;
   // Undriven, unpulled line shows inverse, not a stale value
   assign bIn = bOe ? bOut : drvEn ? drvVal : bPull ? 1'b0 : ~bOut;
endmodule

// file: verification/pfc_pin_function_control_properties.sv
// Port checker for pin function control
// Bound to the design top; one clock, async reset.
module pfc_pin_function_control_properties
(
   input wire core_clk,
   input wire reset,
   input wire regRead,
   input wire [15:0] regAddr,
   input wire [7:0] regRdata_r,
   input wire powerdown_standby_pin,
   input wire [1:0] regPowerMode,
   input wire [1:0] powerMode_r,
   input wire chipPowerDown_r,
   input wire chipStandby_r,
   input wire multipurpose_pin_a_zero_oe,
   input wire pinAPullDown,
   input wire transferStrobe_r
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   chk_modes_apart: assert property (!(chipPowerDown_r && chipStandby_r))
      else $error("powerdown and standby together");
   chk_pd_mode: assert property (chipPowerDown_r |-> powerMode_r == 2'h3)
      else $error("powerdown mode code wrong");
   chk_stby_mode: assert property (chipStandby_r |-> powerMode_r == 2'h2)
      else $error("standby mode code wrong");
   chk_pin_idle: assert property ((!powerdown_standby_pin) [*4] |->
      !chipPowerDown_r && !chipStandby_r)
      else $error("pin low yet power state forced");
   chk_mode_follow: assert property (!chipPowerDown_r && !chipStandby_r
      |-> powerMode_r == $past(regPowerMode))
      else $error("register power mode not passed");
   chk_a_drive: assert property (multipurpose_pin_a_zero_oe |-> !pinAPullDown)
      else $error("driven pin still pulled down");
   chk_xfer_pulse: assert property (transferStrobe_r |=> !transferStrobe_r)
      else $error("transfer strobe longer than a cycle");
   chk_local_zero: assert property (regRead && regAddr == 16'h003f
      |=> regRdata_r[6:0] == 7'h00)
      else $error("reserved local bits not zero");
   cover property (chipPowerDown_r);
   cover property (chipStandby_r);
   cover property (transferStrobe_r);
endmodule
bind pfc_pin_function_control pfc_pin_function_control_properties u_props (
   .core_clk, .reset, .regRead, .regAddr, .regRdata_r, .powerdown_standby_pin,
   .regPowerMode, .powerMode_r, .chipPowerDown_r, .chipStandby_r,
   .multipurpose_pin_a_zero_oe, .pinAPullDown, .transferStrobe_r);

// file: verification/pfc_pin_function_control_tb_top.sv
// Testbench for pin function control
// Board model drives the B0 pin as command asks.
module pfc_pin_function_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, reset, regWrite, regRead, powerdown_standby_pin, aIn, aOut;
   logic [15:0] regAddr;
   logic [7:0] regWdata, regRdata_r;
   logic [1:0] regPowerMode, powerMode_r;
   logic chipPowerDown_r, chipStandby_r, overrange_alert_output, lmfcPulse;
   logic lead_next_trigger_out, aOe, pinAPullDown, bIn, bOut, bOe, pinBPullDown;
   logic ncoChannelSel_r, follower_next_trigger_in_r, transferStrobe_r;
   logic transferDone, drvEn, drvVal;
   int miscompares, compares;
   wire [7:0] pwrState = {4'h0, chipPowerDown_r, chipStandby_r, powerMode_r};
   pfc_pin_function_control u_pfc_pin_function_control (.core_clk, .reset,
      .regWrite, .regRead, .regAddr, .regWdata, .regRdata_r,
      .powerdown_standby_pin, .regPowerMode, .powerMode_r, .chipPowerDown_r,
      .chipStandby_r, .overrange_alert_output, .lmfcPulse,
      .lead_next_trigger_out, .multipurpose_pin_a_zero_in(aIn),
      .multipurpose_pin_a_zero_out(aOut), .multipurpose_pin_a_zero_oe(aOe),
      .pinAPullDown, .multipurpose_pin_b_zero_in(bIn),
      .multipurpose_pin_b_zero_out(bOut), .multipurpose_pin_b_zero_oe(bOe),
      .pinBPullDown, .ncoChannelSel_r, .follower_next_trigger_in_r,
      .transferStrobe_r, .transferDone);
   pfc_board_model u_pfc_board_model (.aOut, .aOe, .bOut, .bOe,
      .bPull(pinBPullDown), .drvEn, .drvVal, .aIn, .bIn);
   task automatic chk(input string n, input logic [7:0] got, exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(posedge core_clk);
      chk("rdata", regRdata_r, exp);
   endtask
   // Sync plus register takes three edges
   task automatic settle;
      repeat (4) @(posedge core_clk);
   endtask
   task automatic strobe_seen;
      logic s;
      s = 1'b0;
      repeat (6)
      begin
         @(posedge core_clk);
         s = s | transferStrobe_r;
      end
      chk("strobe", {7'h0, s}, 8'h01);
   endtask
   task automatic t_reset;
      rc(16'h003f, 8'h00);
      rc(16'h0040, 8'h3f);
      rc(16'h0041, 8'h00);
      rc(16'h0050, 8'h00);
      chk("pins", {5'h0, aOe, pinAPullDown, pinBPullDown}, 8'h03);
   endtask
   task automatic t_power;
      regPowerMode <= 2'h1;
      powerdown_standby_pin <= 1'b1;
      wr(16'h0040, 8'h3f);
      settle;
      chk("power", pwrState, 8'h0b);
      wr(16'h0040, 8'h7f);
      settle;
      chk("power", pwrState, 8'h06);
      wr(16'h0040, 8'hbf);
      settle;
      chk("power", pwrState, 8'h01);
      wr(16'h0040, 8'h3f);
      wr(16'h003f, 8'h80);
      settle;
      chk("power", pwrState, 8'h01);
      powerdown_standby_pin <= 1'b0;
   endtask
   task automatic t_pins;
      wr(16'h0040, 8'h38);
      overrange_alert_output <= 1'b1;
      @(posedge core_clk);
      chk("fd", {6'h0, aOe, aOut}, 8'h03);
      wr(16'h0040, 8'h09);
      lmfcPulse <= 1'b1;
      @(posedge core_clk);
      chk("lmfc", {4'h0, aOe, aOut, bOe, bOut}, 8'h0f);
      wr(16'h0041, 8'h80);
      wr(16'h0040, 8'h3f);
      lead_next_trigger_out <= 1'b1;
      @(posedge core_clk);
      chk("bOff", {7'h0, bOe}, 8'h00);
      wr(16'h0040, 8'h36);
      @(posedge core_clk);
      chk("lead", {5'h0, aOe, bOe, bOut}, 8'h03);
      drvEn <= 1'b1;
      drvVal <= 1'b1;
      wr(16'h0041, 8'h98);
      settle;
      chk("follow", {5'h0, aOe, aOut, follower_next_trigger_in_r}, 8'h07);
      wr(16'h0041, 8'h00);
      settle;
      chk("nco", {7'h0, ncoChannelSel_r}, 8'h01);
      drvVal <= 1'b0;
      settle;
      wr(16'h0041, 8'h10);
      drvVal <= 1'b1;
      strobe_seen;
      drvEn <= 1'b0;
   endtask
   task automatic t_xfer;
      wr(16'h000f, 8'h01);
      strobe_seen;
      rc(16'h000f, 8'h01);
      transferDone <= 1'b1;
      @(posedge core_clk);
      transferDone <= 1'b0;
      rc(16'h000f, 8'h00);
   endtask
   task automatic finish_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial
   begin
      {regWrite, regRead, regAddr, regWdata, powerdown_standby_pin} = '0;
      {regPowerMode, overrange_alert_output, lmfcPulse} = '0;
      {lead_next_trigger_out, transferDone, drvEn, drvVal} = '0;
      {miscompares, compares} = '0;
      reset = 1'b1;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      t_reset;
      t_power;
      t_pins;
      t_xfer;
      finish_test;
   end
endmodule
